// File: hw/cno_pkg.sv
package cno_pkg;
    // ----------------------------------------
    // clock and indicator timing
    // ----------------------------------------
    localparam int unsigned CNO_CLK_HZ = 50_000_000;
    localparam int unsigned CNO_LED_TICK_MS = 200;
    localparam int unsigned CNO_TICK_CYCLES = CNO_CLK_HZ / 1000 * CNO_LED_TICK_MS;
    localparam int unsigned CNO_TEST_TICKS = 5;
    localparam int unsigned CNO_PHASES = 8;

    // ----------------------------------------
    // service data commands and objects
    // ----------------------------------------
    localparam logic [7:0] CNO_CMD_UPLOAD = 8'h40;
    localparam logic [7:0] CNO_CMD_UPLOAD_RSP = 8'h43;
    localparam logic [7:0] CNO_CMD_DOWNLOAD = 8'h23;
    localparam logic [7:0] CNO_CMD_DOWNLOAD_RSP = 8'h60;
    localparam logic [7:0] CNO_CMD_ABORT = 8'h80;
    localparam logic [15:0] CNO_IDX_RATE = 16'h3000;
    localparam logic [15:0] CNO_IDX_NODE = 16'h3001;
    localparam logic [7:0] CNO_SUB_ZERO = 8'h00;
    localparam logic [31:0] CNO_ABORT_NO_OBJ = 32'h0602_0000;
    localparam logic [31:0] CNO_ABORT_RANGE = 32'h0609_0030;
    localparam logic [31:0] CNO_ABORT_CMD = 32'h0504_0001;

    // ----------------------------------------
    // defaults, states, switch fields
    // ----------------------------------------
    localparam logic [2:0] CNO_RATE_DEFAULT = 3'h5;
    localparam logic [6:0] CNO_NODE_DEFAULT = 7'h01;
    localparam logic [1:0] CNO_NET_PREOP = 2'h0;
    localparam logic [1:0] CNO_NET_OP = 2'h1;
    localparam logic [1:0] CNO_NET_STOP = 2'h2;
    localparam int CNO_RATE_SEL_BIT = 3;
    localparam int CNO_SW_W = 12;

    // ----------------------------------------
    // controller register map and fields
    // ----------------------------------------
    localparam logic [7:0] CNO_A_CTRL = 8'h00;
    localparam logic [7:0] CNO_A_INDEX = 8'h04;
    localparam logic [7:0] CNO_A_WDATA = 8'h08;
    localparam logic [7:0] CNO_A_RDATA = 8'h0c;
    localparam logic [7:0] CNO_A_STATUS = 8'h10;
    localparam int CNO_CTRL_UP = 0;
    localparam int CNO_CTRL_DN = 1;
    localparam int CNO_CTRL_RST = 2;
    localparam int CNO_ST_BUSY = 0;
    localparam int CNO_ST_DONE = 1;
    localparam int CNO_ST_ABORT = 2;
    localparam int CNO_ST_RANGE = 3;

    // rate code to kbit/s: 20,50,100,125,250,500,800,1000
    function automatic logic [9:0] cno_rate_kbps(input logic [2:0] code);
        logic [9:0] k;
        k = 10'h014;
        unique case (code)
            3'h0: k = 10'h014;
            3'h1: k = 10'h032;
            3'h2: k = 10'h064;
            3'h3: k = 10'h07d;
            3'h4: k = 10'h0fa;
            3'h5: k = 10'h1f4;
            3'h6: k = 10'h320;
            3'h7: k = 10'h3e8;
        endcase
        return k;
    endfunction

    // node numbers valid only from 1 to 127
    function automatic logic cno_node_ok(input logic [31:0] v);
        return (v[31:7] == 25'h0000000) && (v[6:0] != 7'h00);
    endfunction
endpackage

// File: hw/cno_link_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// sdo frame link, byte k at bits 8k+7:8k
// ----------------------------------------
interface cno_link_if;
    logic req_valid;
    logic req_ready;
    logic [63:0] req_frame;
    logic rsp_valid;
    logic rsp_ready;
    logic [63:0] rsp_frame;
    logic node_reset;
    modport dev (input req_valid, input req_frame, input rsp_ready, input node_reset,
                 output req_ready, output rsp_valid, output rsp_frame);
    modport mst (output req_valid, output req_frame, output rsp_ready, output node_reset,
                 input req_ready, input rsp_valid, input rsp_frame);
endinterface

// File: hw/cno_node_dev.sv
`timescale 1ns/1ps
// How it works
// - rate switch four selects switches or object
// - rate switches one-three binary, one lsb
// - codes 0-7 map 20 to 1000 kbit/s
// - defaults: 500 kbit/s, node one
// - any of address switches one-seven on selects switches
// - address switches one-seven binary, eight ignored
// - only node numbers 1 to 127 accepted
// - master stores parameters then resets node
// - green: on, single flash, blinking
// - red: off-bus, double, single, blink, dark
// - both indicators lit during init test
// - upload 40h request, 43h reply, lsb first
module cno_node_dev
    import cno_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = CNO_TICK_CYCLES,
    parameter int unsigned TEST_TICKS = CNO_TEST_TICKS
) (
    input wire logic hclk,
    input wire logic hresetn,
    cno_link_if.dev link,
    input wire logic [3:0] rate_sw,
    input wire logic [7:0] addr_sw,
    input wire logic [1:0] net_state,
    input wire logic bus_off,
    input wire logic guard_err,
    input wire logic warn_limit,
    input wire logic gen_err,
    output logic led_green,
    output logic led_red,
    output logic [2:0] rate_code,
    output logic [9:0] bitrate_kbps,
    output logic [6:0] node_number,
    output logic setup_valid
);
    // refuse timing the counters cannot serve
    if (TICK_CYCLES < 2 || TEST_TICKS < 1 || TEST_TICKS > 255) begin : g_bad_timing
        $error("cno_node_dev: unsupported timing parameters");
    end

    localparam int TW = $clog2(TICK_CYCLES);

    typedef enum logic [1:0] {
        ST_TEST = 2'b01,
        ST_RUN = 2'b10
    } cno_dev_state_t;

    // ----------------------------------------
    // switch synchronisers
    // ----------------------------------------
    logic [CNO_SW_W-1:0] sw_s1_r, sw_s2_r, sw_s3_r, sw_st_r;
    logic [CNO_SW_W-1:0] sw_st_nxt;
    wire logic [CNO_SW_W-1:0] sw_raw = {addr_sw, rate_sw};
    wire logic [CNO_SW_W-1:0] sw_diff = sw_s2_r ^ sw_s3_r;

    // a bit moves only once two stages agree, so bounce is ignored
    assign sw_st_nxt = (sw_s2_r & ~sw_diff) | (sw_st_r & sw_diff);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_s1_r <= '0;
            sw_s2_r <= '0;
            sw_s3_r <= '0;
            sw_st_r <= '0;
        end else begin
            sw_s1_r <= sw_raw;
            sw_s2_r <= sw_s1_r;
            sw_s3_r <= sw_s2_r;
            sw_st_r <= sw_st_nxt;
        end
    end

    // ----------------------------------------
    // indicator time base
    // ----------------------------------------
    logic [TW-1:0] tick_cnt_r;
    logic [2:0] phase_r;
    logic [7:0] test_cnt_r;
    cno_dev_state_t state_r, state_nxt;
    wire logic tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));
    wire logic test_done = tick && (test_cnt_r == 8'(TEST_TICKS - 1));
    // restart the time base on node reset, else the lamp test could last a single cycle
    wire logic restart = (state_r == ST_RUN) && link.node_reset;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_r <= '0;
            phase_r <= 3'h0;
        end else begin
            tick_cnt_r <= (tick || restart) ? '0 : tick_cnt_r + TW'(1);
            phase_r <= tick ? phase_r + 3'h1 : phase_r;
        end
    end

    // ----------------------------------------
    // init test and run state
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_TEST: if (test_done) begin
                state_nxt = ST_RUN;
            end
            ST_RUN: if (link.node_reset) begin
                state_nxt = ST_TEST;
            end
            default: state_nxt = ST_TEST;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_TEST;
            test_cnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            test_cnt_r <= (state_r != ST_TEST) ? 8'h00 : (tick ? test_cnt_r + 8'h01 : test_cnt_r);
        end
    end

    // ----------------------------------------
    // stored objects and setup selection
    // ----------------------------------------
    logic [2:0] rate_obj_r;
    logic [6:0] node_obj_r;
    wire logic [2:0] sw_rate = sw_st_r[2:0];
    wire logic [6:0] sw_node = sw_st_r[10:4];
    wire logic [2:0] rate_sel = sw_st_r[CNO_RATE_SEL_BIT] ? sw_rate : rate_obj_r;
    wire logic [6:0] node_sel = (sw_node != 7'h00) ? sw_node : node_obj_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_code <= CNO_RATE_DEFAULT;
            bitrate_kbps <= cno_rate_kbps(CNO_RATE_DEFAULT);
            node_number <= CNO_NODE_DEFAULT;
            setup_valid <= 1'b0;
        end else if (state_r == ST_TEST && test_done) begin
            rate_code <= rate_sel;
            bitrate_kbps <= cno_rate_kbps(rate_sel);
            node_number <= node_sel;
            setup_valid <= 1'b1;
        end else if (state_r == ST_TEST) begin
            setup_valid <= 1'b0;
        end
    end

    // ----------------------------------------
    // sdo request decode
    // ----------------------------------------
    logic rsp_pend_r;
    logic [63:0] rsp_frame_r;
    wire logic [7:0] q_cmd = link.req_frame[7:0];
    wire logic [15:0] q_idx = link.req_frame[23:8];
    wire logic [7:0] q_sub = link.req_frame[31:24];
    wire logic [31:0] q_data = link.req_frame[63:32];
    wire logic hit_rate = (q_idx == CNO_IDX_RATE) && (q_sub == CNO_SUB_ZERO);
    wire logic hit_node = (q_idx == CNO_IDX_NODE) && (q_sub == CNO_SUB_ZERO);
    wire logic is_up = (q_cmd == CNO_CMD_UPLOAD);
    wire logic is_dn = (q_cmd == CNO_CMD_DOWNLOAD);
    wire logic rate_ok = (q_data[31:3] == 29'h00000000);
    wire logic node_ok = cno_node_ok(q_data);
    // sdo is refused in stopped state and during the init test
    wire logic sdo_open = (state_r == ST_RUN) && (net_state != CNO_NET_STOP);
    wire logic take = link.req_valid && link.req_ready;
    wire logic wr_rate = take && is_dn && hit_rate && rate_ok;
    wire logic wr_node = take && is_dn && hit_node && node_ok;
    wire logic [31:0] up_val = hit_rate ? {29'h00000000, rate_obj_r} : {25'h0000000, node_obj_r};
    wire logic known = hit_rate || hit_node;
    wire logic dn_bad = (hit_rate && !rate_ok) || (hit_node && !node_ok);

    logic [7:0] r_cmd;
    logic [31:0] r_data;
    // reply command and payload; abort answers carry the reason code
    assign r_cmd = (!(is_up || is_dn)) ? CNO_CMD_ABORT :
                   (!known) ? CNO_CMD_ABORT :
                   (is_up) ? CNO_CMD_UPLOAD_RSP :
                   (dn_bad) ? CNO_CMD_ABORT : CNO_CMD_DOWNLOAD_RSP;
    assign r_data = (!(is_up || is_dn)) ? CNO_ABORT_CMD :
                    (!known) ? CNO_ABORT_NO_OBJ :
                    (is_up) ? up_val :
                    (dn_bad) ? CNO_ABORT_RANGE : 32'h00000000;

    assign link.req_ready = sdo_open && !rsp_pend_r;
    assign link.rsp_valid = rsp_pend_r;
    assign link.rsp_frame = rsp_frame_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp_pend_r <= 1'b0;
            rsp_frame_r <= 64'h0;
        end else if (take) begin
            rsp_pend_r <= 1'b1;
            rsp_frame_r <= {r_data, q_sub, q_idx, r_cmd};
        end else if (link.rsp_ready) begin
            rsp_pend_r <= 1'b0;
        end
    end

    // objects take effect at the next init, not at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_obj_r <= CNO_RATE_DEFAULT;
            node_obj_r <= CNO_NODE_DEFAULT;
        end else begin
            rate_obj_r <= wr_rate ? q_data[2:0] : rate_obj_r;
            node_obj_r <= wr_node ? q_data[6:0] : node_obj_r;
        end
    end

    // ----------------------------------------
    // indicator patterns
    // ----------------------------------------
    wire logic pat_blink = ~phase_r[0];
    wire logic pat_single = (phase_r == 3'h0);
    wire logic pat_double = (phase_r == 3'h0) || (phase_r == 3'h2);
    logic green_nxt, red_nxt;

    assign green_nxt = (net_state == CNO_NET_OP) ? 1'b1 :
                       (net_state == CNO_NET_STOP) ? pat_single : pat_blink;
    assign red_nxt = bus_off ? 1'b1 :
                     guard_err ? pat_double :
                     warn_limit ? pat_single :
                     gen_err ? pat_blink : 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_green <= 1'b1;
            led_red <= 1'b1;
        end else begin
            led_green <= (state_r == ST_TEST) ? 1'b1 : green_nxt;
            led_red <= (state_r == ST_TEST) ? 1'b1 : red_nxt;
        end
    end
endmodule // cno_node_dev

// File: hw/cno_master.sv
`timescale 1ns/1ps
module cno_master
    import cno_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    cno_link_if.mst link
);
    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_SEND = 3'b010,
        M_WAIT = 3'b100
    } cno_mst_state_t;

    // ----------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    wire logic a_take = hsel && hready && htrans[1];
    wire logic wr_ctrl = wr_pend_r && (wr_addr_r == CNO_A_CTRL);
    wire logic wr_index = wr_pend_r && (wr_addr_r == CNO_A_INDEX);
    wire logic wr_wdata = wr_pend_r && (wr_addr_r == CNO_A_WDATA);
    wire logic wr_status = wr_pend_r && (wr_addr_r == CNO_A_STATUS);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= a_take && hwrite;
            wr_addr_r <= a_take ? haddr : wr_addr_r;
        end
    end

    // ----------------------------------------
    // command registers and status
    // ----------------------------------------
    cno_mst_state_t st_r, st_nxt;
    logic [23:0] index_r;
    logic [31:0] wdata_r, rdata_r;
    logic [63:0] frame_r;
    logic done_r, abort_r, range_r, nreset_r;
    wire logic idle = (st_r == M_IDLE);
    wire logic go_up = wr_ctrl && hwdata[CNO_CTRL_UP] && idle;
    wire logic go_dn = wr_ctrl && hwdata[CNO_CTRL_DN] && !hwdata[CNO_CTRL_UP] && idle;
    wire logic node_tgt = (index_r[15:0] == CNO_IDX_NODE) && (index_r[23:16] == CNO_SUB_ZERO);
    wire logic dn_bad = go_dn && node_tgt && !cno_node_ok(wdata_r);
    wire logic launch = go_up || (go_dn && !dn_bad);
    wire logic got_rsp = (st_r == M_WAIT) && link.rsp_valid;
    wire logic [31:0] status_w = {28'h0000000, range_r, abort_r, done_r, !idle};
    wire logic [31:0] rd_mux = (haddr == CNO_A_INDEX) ? {8'h00, index_r} :
                               (haddr == CNO_A_WDATA) ? wdata_r :
                               (haddr == CNO_A_RDATA) ? rdata_r :
                               (haddr == CNO_A_STATUS) ? status_w : 32'h00000000;
    wire logic clr_done = wr_status && hwdata[CNO_ST_DONE];

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            M_IDLE: if (launch) begin
                st_nxt = M_SEND;
            end
            M_SEND: if (link.req_ready) begin
                st_nxt = M_WAIT;
            end
            M_WAIT: if (link.rsp_valid) begin
                st_nxt = M_IDLE;
            end
            default: st_nxt = M_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= M_IDLE;
            index_r <= 24'h000000;
            wdata_r <= 32'h00000000;
            frame_r <= 64'h0;
            hrdata <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
            index_r <= wr_index ? hwdata[23:0] : index_r;
            wdata_r <= wr_wdata ? hwdata : wdata_r;
            // request frame, index low byte first
            frame_r <= !launch ? frame_r : go_up ? {32'h00000000, index_r, CNO_CMD_UPLOAD} :
                       {wdata_r, index_r, CNO_CMD_DOWNLOAD};
            hrdata <= (a_take && !hwrite) ? rd_mux : hrdata;
        end
    end

    // sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_r <= 1'b0;
            abort_r <= 1'b0;
            range_r <= 1'b0;
            rdata_r <= 32'h00000000;
            nreset_r <= 1'b0;
        end else begin
            done_r <= (got_rsp || dn_bad) ? 1'b1 : (clr_done ? 1'b0 : done_r);
            abort_r <= got_rsp ? (link.rsp_frame[7:0] == CNO_CMD_ABORT) : (launch ? 1'b0 : abort_r);
            range_r <= dn_bad ? 1'b1 : (launch ? 1'b0 : range_r);
            rdata_r <= got_rsp ? link.rsp_frame[63:32] : rdata_r;
            nreset_r <= wr_ctrl && hwdata[CNO_CTRL_RST] && idle;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link.req_valid = (st_r == M_SEND);
    assign link.req_frame = frame_r;
    assign link.rsp_ready = (st_r == M_WAIT);
    assign link.node_reset = nreset_r;
endmodule // cno_master

// File: test/cno_checker.sv
`timescale 1ns/1ps
module cno_checker
    import cno_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [63:0] req_frame,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [63:0] rsp_frame,
    input wire logic node_reset
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------------------------
    // decode of the request on the link
    // ------------------------------
    wire take = req_valid && req_ready;
    wire [7:0] cmd = req_frame[7:0];
    wire sub0 = req_frame[31:24] == CNO_SUB_ZERO;
    wire is_rate = req_frame[23:8] == CNO_IDX_RATE && sub0;
    wire is_node = req_frame[23:8] == CNO_IDX_NODE && sub0;
    wire up = take && cmd == CNO_CMD_UPLOAD;
    property p_up_reply;
        up && (is_rate || is_node) |=> rsp_valid && rsp_frame[7:0] == CNO_CMD_UPLOAD_RSP;
    endproperty
    a_up_reply: assert property (p_up_reply) else $error("upload reply missing or wrong");
    property p_echo;
        take |=> rsp_frame[31:8] == $past(req_frame[31:8]);
    endproperty
    a_echo: assert property (p_echo) else $error("reply index not echoed");
    property p_rsp_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_frame);
    endproperty
    a_rsp_hold: assert property (p_rsp_hold) else $error("reply dropped early");
    property p_req_hold;
        req_valid && !req_ready |=> req_valid && $stable(req_frame);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");
    property p_one_out;
        rsp_valid |-> !req_ready;
    endproperty
    a_one_out: assert property (p_one_out) else $error("request accepted with reply pending");
    property p_rate_data;
        up && is_rate |=> rsp_frame[63:35] == 29'h0;
    endproperty
    a_rate_data: assert property (p_rate_data) else $error("rate object out of range");
    property p_node_data;
        up && is_node |=> rsp_frame[63:39] == 25'h0 && rsp_frame[38:32] != 7'h00;
    endproperty
    a_node_data: assert property (p_node_data) else $error("node object out of range");
    property p_rate_abort;
        take && cmd == CNO_CMD_DOWNLOAD && is_rate && req_frame[63:32] > 32'h7
            |=> rsp_frame[7:0] == CNO_CMD_ABORT && rsp_frame[63:32] == CNO_ABORT_RANGE;
    endproperty
    a_rate_abort: assert property (p_rate_abort) else $error("bad rate code not refused");
    property p_reinit;
        node_reset |=> (!node_reset && !req_ready)[*3];
    endproperty
    a_reinit: assert property (p_reinit) else $error("node reset did not restart init");
    c_up: cover property (up && is_node);
    c_abort: cover property (rsp_valid && rsp_frame[7:0] == CNO_CMD_ABORT);
    c_reinit: cover property (node_reset);
endmodule // cno_checker

// File: test/canopen_node_setup_and_status_test.sv
`timescale 1ns/1ps
module canopen_node_setup_and_status_test;
    import cno_pkg::*;
    localparam int TK = 8;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, st, rd, du;
    logic hreadyout, hresp, led_green, led_red, setup_valid;
    logic [3:0] rate_sw = 4'h0;
    logic [7:0] addr_sw = 8'h80;
    logic [1:0] net_state = 2'h0;
    logic [3:0] errs = 4'h0;
    logic [2:0] rate_code;
    logic [9:0] bitrate_kbps;
    logic [6:0] node_number;
    int miscompares = 0, num_checks = 0, seed = 32'h61b3;
    int obj_rate = 5, obj_node = 1, er, en;
    int kbps[8] = '{20, 50, 100, 125, 250, 500, 800, 1000};
    cno_link_if link ();
    cno_node_dev #(.TICK_CYCLES(TK), .TEST_TICKS(1)) cno_node_dev_i (.hclk(hclk), .hresetn(hresetn),
        .link(link), .rate_sw(rate_sw), .addr_sw(addr_sw), .net_state(net_state), .bus_off(errs[3]),
        .guard_err(errs[2]), .warn_limit(errs[1]), .gen_err(errs[0]), .led_green(led_green),
        .led_red(led_red), .rate_code(rate_code), .bitrate_kbps(bitrate_kbps),
        .node_number(node_number), .setup_valid(setup_valid));
    cno_master cno_master_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(link));
    cno_checker cno_checker_i (.hclk(hclk), .hresetn(hresetn), .req_valid(link.req_valid),
        .req_ready(link.req_ready), .req_frame(link.req_frame), .rsp_valid(link.rsp_valid),
        .rsp_ready(link.rsp_ready), .rsp_frame(link.rsp_frame), .node_reset(link.node_reset));
    always #10 hclk = ~hclk;
    // ------------------------------
    // checking and closing
    // ------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic give_up(input string nm);
        chk(nm, 0, 1);
        end_of_test();
    endtask
    // ------------------------------
    // bus and link tasks
    // ------------------------------
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) give_up("hready");
    endtask
    // address phase held until hready, then data phase until hready
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        r = hrdata;
    endtask
    // one sdo exchange; st keeps the status that showed done
    task automatic op(input logic [2:0] c, input logic [15:0] ix, input logic [31:0] wd);
        int n;
        ahb(1'b1, CNO_A_INDEX, {16'h0000, ix}, du);
        ahb(1'b1, CNO_A_WDATA, wd, du);
        ahb(1'b1, CNO_A_CTRL, {29'h0, c}, du);
        n = 0;
        do begin
            ahb(1'b0, CNO_A_STATUS, 32'h0, st);
            n++;
        end while (st[CNO_ST_DONE] !== 1'b1 && n < 50);
        if (st[CNO_ST_DONE] !== 1'b1) give_up("done");
        ahb(1'b0, CNO_A_RDATA, 32'h0, rd);
        ahb(1'b1, CNO_A_STATUS, 32'h2, du);
    endtask
    task automatic wait_sv(input logic v);
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (setup_valid !== v && n < 400);
        if (setup_valid !== v) give_up("setup_valid");
    endtask
    // model: switches win over stored objects
    task automatic exp_setup();
        er = rate_sw[3] ? int'(rate_sw[2:0]) : obj_rate;
        en = (addr_sw[6:0] != 7'h00) ? int'(addr_sw[6:0]) : obj_node;
    endtask
    task automatic chk_setup();
        chk("rate_code", rate_code, er);
        chk("bitrate", bitrate_kbps, kbps[er]);
        chk("node_number", node_number, en);
    endtask
    task automatic reinit();
        ahb(1'b1, CNO_A_CTRL, 32'h4, du);
        wait_sv(1'b0);
        wait_sv(1'b1);
    endtask
    // on-cycles over one full 8-tick pattern
    task automatic led(input logic [1:0] ns, input logic [3:0] e, input int g, input int r);
        int ng, nr;
        ng = 0;
        nr = 0;
        @(posedge hclk);
        net_state <= ns;
        errs <= e;
        repeat (3) @(negedge hclk);
        repeat (8 * TK) begin
            @(negedge hclk);
            ng += int'(led_green === 1'b1);
            nr += int'(led_red === 1'b1);
        end
        chk("green_on", ng, g);
        chk("red_on", nr, r);
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk("green_init", led_green, 1);
        chk("red_init", led_red, 1);
        wait_sv(1'b1);
        exp_setup();
        chk_setup();
        op(3'h1, CNO_IDX_NODE, 0);
        chk("up_node", rd, obj_node);
        $display("test defaults done");
        for (int i = 0; i < 4; i++) begin
            obj_rate = $unsigned($random(seed)) % 8;
            obj_node = (i == 3) ? 127 : $unsigned($random(seed)) % 127 + 1;
            op(3'h2, CNO_IDX_RATE, obj_rate);
            op(3'h2, CNO_IDX_NODE, obj_node);
            op(3'h1, CNO_IDX_RATE, 0);
            chk("up_rate", rd, obj_rate);
        end
        // refusals leave the stored objects alone
        op(3'h2, CNO_IDX_NODE, 0);
        chk("node_zero", st[CNO_ST_RANGE], 1);
        op(3'h2, CNO_IDX_NODE, 128);
        chk("node_128", st[CNO_ST_RANGE], 1);
        op(3'h2, CNO_IDX_RATE, 8);
        chk("rate_abort", st[CNO_ST_ABORT], 1);
        chk("abort_code", rd, CNO_ABORT_RANGE);
        op(3'h1, 16'h6502, 0);
        chk("no_obj", rd, CNO_ABORT_NO_OBJ);
        op(3'h1, CNO_IDX_NODE, 0);
        chk("node_kept", rd, obj_node);
        ahb(1'b0, 8'h20, 32'h0, rd);
        chk("unmapped", rd, 0);
        reinit();
        exp_setup();
        chk_setup();
        $display("test objects done");
        for (int c = 0; c < 8; c++) begin
            @(posedge hclk);
            rate_sw <= {1'b1, 3'(c)};
            addr_sw <= 8'($random(seed));
            repeat (6) @(posedge hclk);
            reinit();
            exp_setup();
            chk_setup();
            @(posedge hclk);
            rate_sw <= ~rate_sw;
            addr_sw <= ~addr_sw;
            repeat (20) @(negedge hclk);
            chk_setup();
        end
        $display("test switches done");
        led(CNO_NET_OP, 4'h0, 8 * TK, 0);
        led(CNO_NET_STOP, 4'h8, TK, 8 * TK);
        led(CNO_NET_PREOP, 4'h4, 4 * TK, 2 * TK);
        led(2'h3, 4'h2, 4 * TK, TK);
        led(CNO_NET_OP, 4'h1, 8 * TK, 4 * TK);
        led(CNO_NET_STOP, 4'h6, TK, 2 * TK);
        $display("test indicators done");
        end_of_test();
    end
endmodule // canopen_node_setup_and_status_test
